// ---- lid_decoder.sv ----
// loop setup and immediate move decode stage with apb control
// Functional notes
// - 000/01100: load 16-bit immediate loop count
// - 000/01101/0: loop count from universal register
// - loop end is instruction address plus offset
// - termination loop passes exit condition field
// - 000/100: absolute move, 8+24 bit address
// - direction bit picks memory read or write
// - long-word bit forces long access in range (absolute move only; indexed moves never set it)
// - universal selector names transfer register
// - 101: indexed move, 32-bit immediate modify
// - short indexed move: 1001, subfield 010
// - 100 then one: 32-bit index/modify load
// - generator bit picks data or program generator
// - short index/modify load: 1001, subfield 001
// - 000/01111/0: 32-bit universal register load
// - 01111 then one: 16-bit universal load
// - 000/10100: one of five bit operations
// - system register field names bit op target
//
// The implementer's own choices: the APB slave port and the register offsets.
`include "lid_map.svh"
`default_nettype none
module lid_decoder (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [4:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // instruction from fetch
  input  wire logic                 instr_valid,
  input  wire logic                 instr_short,
  input  wire logic [47:0]          instr_word,
  input  wire logic [23:0]          instr_addr,
  // decoded controls
  output logic                      dec_valid,
  output lid_pkg::lid_kind_type     dec_kind,
  output lid_pkg::lid_loop_type     dec_loop,
  output lid_pkg::lid_mem_type      dec_mem,
  output lid_pkg::lid_imm_type      dec_imm,
  output lid_pkg::lid_bit_type      dec_bit
);
  logic                  pready_r;
  logic [31:0]           prdata_r;
  logic                  pslverr_r;
  logic                  enable_r;
  logic [31:0]           nwlo_r;
  logic [31:0]           nwhi_r;
  logic [15:0]           dec_cnt_r;
  logic [15:0]           bad_cnt_r;
  logic                  dec_valid_r;
  lid_pkg::lid_kind_type kind_r;
  lid_pkg::lid_kind_type kind_nxt;
  lid_pkg::lid_loop_type loop_r;
  lid_pkg::lid_loop_type loop_nxt;
  lid_pkg::lid_mem_type  mem_r;
  lid_pkg::lid_mem_type  mem_nxt;
  lid_pkg::lid_imm_type  imm_r;
  lid_pkg::lid_imm_type  imm_nxt;
  lid_pkg::lid_bit_type  bit_r;
  lid_pkg::lid_bit_type  bit_nxt;
  logic [31:0]           s;
  logic                  apb_acc;
  logic                  apb_wr;
  logic                  mapped;
  logic [31:0]           rd_val;

  assign s = instr_word[47:16];

  // apb: one wait state, answer registered
  assign apb_acc = psel & penable & ~pready_r;
  assign apb_wr  = psel & penable & pready_r & pwrite;
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    case (paddr)
      `LID_OFF_CTRL: rd_val = {31'h00000000, enable_r};
      `LID_OFF_NWLO: rd_val = nwlo_r;
      `LID_OFF_NWHI: rd_val = nwhi_r;
      `LID_OFF_STAT: rd_val = {bad_cnt_r, dec_cnt_r};
      `LID_OFF_LAST: rd_val = {28'h0000000, kind_r};
      default:       mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apb_acc;
      pslverr_r <= apb_acc & ~mapped;
      // unmapped or write access reads back zero
      prdata_r  <= (apb_acc & ~pwrite) ? rd_val : 32'h00000000;
    end
  end

  // software controls: enable and normal word range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= `LID_CTRL_RST;
      nwlo_r   <= `LID_NWLO_RST;
      nwhi_r   <= `LID_NWHI_RST;
    end else if (apb_wr) begin
      if (paddr == `LID_OFF_CTRL) enable_r <= pwdata[0];
      if (paddr == `LID_OFF_NWLO) nwlo_r <= pwdata;
      if (paddr == `LID_OFF_NWHI) nwhi_r <= pwdata;
    end
  end

  // decode: one form per accepted word, everything else is a nop
  always_comb begin
    kind_nxt = lid_pkg::KIND_NONE;
    loop_nxt = '0;
    mem_nxt  = '0;
    imm_nxt  = '0;
    bit_nxt  = '0;
    if (instr_valid && enable_r && instr_short) begin
      if (s[`LID_SPFX] == `LID_SPFX_VAL &&
          s[`LID_SSUB] == `LID_SSUB_IDX) begin
        kind_nxt            = lid_pkg::KIND_MIDX;
        mem_nxt.valid       = 1'b1;
        mem_nxt.indexed     = 1'b1;
        mem_nxt.idx         = s[`LID_SI];
        mem_nxt.write_mem   = s[`LID_SD];
        mem_nxt.long_word_req = s[`LID_SL];
        mem_nxt.gen_sel     = s[`LID_SG15];
        mem_nxt.ureg        = s[`LID_SUREG15];
        // short modify is signed, widened to the full word
        mem_nxt.addr_or_mod = {{25{s[6]}}, s[`LID_SMOD]};
      end else if (s[`LID_SPFX] == `LID_SPFX_VAL &&
                   s[`LID_SSUB] == `LID_SSUB_IM) begin
        kind_nxt         = lid_pkg::KIND_IMLD;
        imm_nxt.idx_load = 1'b1;
        imm_nxt.mod_load = 1'b1;
        imm_nxt.reg_sel  = s[`LID_SI];
        imm_nxt.gen_sel  = s[`LID_SG16];
        imm_nxt.data     = {{16{s[15]}}, s[`LID_SDAT16]};
        // the m field picks the modify register for the same load
        imm_nxt.ureg     = {4'h0, s[`LID_SM]};
      end else if (s[`LID_STOP3] == `LID_TOP_000 &&
                   s[`LID_SOP5] == `LID_OP_UIMM && s[`LID_SBIT]) begin
        kind_nxt          = lid_pkg::KIND_ULD;
        imm_nxt.ureg_load = 1'b1;
        imm_nxt.ureg      = s[`LID_SUREG17];
        imm_nxt.data      = {{16{s[15]}}, s[`LID_SDAT16]};
      end
    end else if (instr_valid && enable_r) begin
      case (instr_word[`LID_TOP3])
        `LID_TOP_000: begin
          if (instr_word[`LID_OP6] == `LID_OP6_ABS) begin
            kind_nxt = lid_pkg::KIND_MABS;
            mem_nxt.valid     = 1'b1;
            mem_nxt.gen_sel   = instr_word[`LID_G14];
            mem_nxt.write_mem = instr_word[`LID_D14];
            mem_nxt.long_word_req = instr_word[`LID_L14];
            mem_nxt.ureg      = instr_word[`LID_UREG];
            mem_nxt.addr_or_mod = instr_word[`LID_IMM32];
            // address known here, so range check is done now
            mem_nxt.long_word_access = instr_word[`LID_L14] &&
              instr_word[`LID_IMM32] >= nwlo_r &&
              instr_word[`LID_IMM32] <= nwhi_r;
          end else begin
            case (instr_word[`LID_OP5])
              `LID_OP_LCNT: begin
                kind_nxt       = lid_pkg::KIND_LCNT;
                loop_nxt.start = 1'b1;
                loop_nxt.count = instr_word[`LID_LCNT];
                loop_nxt.end_addr = instr_addr +
                  instr_word[`LID_REL];
              end
              `LID_OP_LUREG: begin
                if (!instr_word[`LID_ZBIT]) begin
                  kind_nxt = lid_pkg::KIND_LCNT;
                  loop_nxt.start = 1'b1;
                  loop_nxt.count_from_ureg = 1'b1;
                  loop_nxt.count_ureg = instr_word[`LID_UREG];
                  loop_nxt.end_addr = instr_addr +
                    instr_word[`LID_REL];
                end
              end
              `LID_OP_LTERM: begin
                kind_nxt = lid_pkg::KIND_LTERM;
                loop_nxt.start = 1'b1;
                loop_nxt.until_term = 1'b1;
                loop_nxt.term = instr_word[`LID_TERM];
                loop_nxt.end_addr = instr_addr +
                  instr_word[`LID_REL];
              end
              `LID_OP_UIMM: begin
                if (!instr_word[`LID_ZBIT]) begin
                  kind_nxt = lid_pkg::KIND_ULD;
                  imm_nxt.ureg_load = 1'b1;
                  imm_nxt.ureg = instr_word[`LID_UREG];
                  imm_nxt.data = instr_word[`LID_IMM32];
                end
              end
              `LID_OP_BIT: begin
                // codes above the fifth operation stay a nop
                if (instr_word[`LID_BIT_OP] <= `LID_BIT_OP_LAST) begin
                  kind_nxt = lid_pkg::KIND_BIT;
                  bit_nxt.valid = 1'b1;
                  bit_nxt.op   = instr_word[`LID_BIT_OP];
                  bit_nxt.sys_reg_sel = instr_word[`LID_SYS_REG];
                  bit_nxt.data = instr_word[`LID_IMM32];
                end
              end
              default: kind_nxt = lid_pkg::KIND_NONE;
            endcase
          end
        end
        `LID_TOP_100: begin
          if (instr_word[`LID_B16]) begin
            kind_nxt = lid_pkg::KIND_IMLD;
            imm_nxt.idx_load = 1'b1;
            imm_nxt.mod_load = 1'b1;
            imm_nxt.reg_sel  = instr_word[`LID_I16];
            imm_nxt.ureg     = {4'h0, instr_word[`LID_M16]};
            imm_nxt.gen_sel  = instr_word[`LID_G16];
            imm_nxt.data     = instr_word[`LID_IMM32];
          end
        end
        `LID_TOP_101: begin
          kind_nxt = lid_pkg::KIND_MIDX;
          mem_nxt.valid     = 1'b1;
          mem_nxt.indexed   = 1'b1;
          mem_nxt.gen_sel   = instr_word[`LID_G15];
          mem_nxt.idx       = instr_word[`LID_I15];
          mem_nxt.write_mem = instr_word[`LID_D15];
          mem_nxt.long_word_req = instr_word[`LID_L15];
          mem_nxt.ureg      = instr_word[`LID_UREG];
          mem_nxt.addr_or_mod = instr_word[`LID_IMM32];
        end
        default: kind_nxt = lid_pkg::KIND_NONE;
      endcase
    end
  end

  // one registered result per accepted word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_valid_r <= 1'b0;
      kind_r      <= lid_pkg::KIND_NONE;
      loop_r      <= '0;
      mem_r       <= '0;
      imm_r       <= '0;
      bit_r       <= '0;
    end else begin
      dec_valid_r <= kind_nxt != lid_pkg::KIND_NONE;
      kind_r      <= kind_nxt;
      loop_r      <= loop_nxt;
      mem_r       <= mem_nxt;
      imm_r       <= imm_nxt;
      bit_r       <= bit_nxt;
    end
  end

  // counters saturate so software never sees a wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_cnt_r <= 16'h0000;
      bad_cnt_r <= 16'h0000;
    end else if (instr_valid && enable_r) begin
      if (kind_nxt != lid_pkg::KIND_NONE && dec_cnt_r != 16'hFFFF)
        dec_cnt_r <= dec_cnt_r + 16'h0001;
      if (kind_nxt == lid_pkg::KIND_NONE && bad_cnt_r != 16'hFFFF)
        bad_cnt_r <= bad_cnt_r + 16'h0001;
    end
  end

  assign pready    = pready_r;
  assign prdata    = prdata_r;
  assign pslverr   = pslverr_r;
  assign dec_valid = dec_valid_r;
  assign dec_kind  = kind_r;
  assign dec_loop  = loop_r;
  assign dec_mem   = mem_r;
  assign dec_imm   = imm_r;
  assign dec_bit   = bit_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_loop_count_imm: assert property (
    instr_valid && enable_r && !instr_short &&
    instr_word[47:40] == 8'h0C |=>
    dec_loop.start && dec_loop.count == $past(instr_word[39:24]))
    else $error("immediate loop count not loaded");
  a_loop_from_ureg: assert property (
    instr_valid && enable_r && !instr_short &&
    instr_word[47:39] == 9'h01A |=>
    dec_loop.count_from_ureg &&
    dec_loop.count_ureg == $past(instr_word[38:32]))
    else $error("loop count register not passed");
  a_loop_end_sum: assert property (
    dec_loop.start |->
    dec_loop.end_addr == $past(instr_addr) + $past(instr_word[23:0]))
    else $error("loop end address wrong");
  a_loop_term_cond: assert property (
    dec_kind == lid_pkg::KIND_LTERM |->
    dec_loop.until_term && dec_loop.term == $past(instr_word[37:33]))
    else $error("termination condition lost");
  a_mem_abs_addr: assert property (
    dec_kind == lid_pkg::KIND_MABS |->
    !dec_mem.indexed && dec_mem.addr_or_mod == $past(instr_word[31:0]))
    else $error("absolute address wrong");
  a_abs_dir_bit: assert property (
    dec_kind == lid_pkg::KIND_MABS |->
    dec_mem.write_mem == $past(instr_word[40]))
    else $error("transfer direction wrong");
  a_mem_long_range: assert property (
    dec_mem.long_word_access |->
    $past(instr_word[39]) && $past(instr_word[31:0]) >= $past(nwlo_r) &&
    $past(instr_word[31:0]) <= $past(nwhi_r))
    else $error("long word forced outside range");
  a_short_mod_sext: assert property (
    dec_mem.indexed && $past(instr_short) |->
    dec_mem.addr_or_mod[31:7] == {25{dec_mem.addr_or_mod[6]}})
    else $error("short modify not sign extended");
  a_bit_op_range: assert property (
    dec_bit.valid |-> dec_bit.op <= 3'h4 &&
    dec_bit.sys_reg_sel == $past(instr_word[36:32]))
    else $error("bit operation out of range");
  a_nop_when_off: assert property (
    !enable_r || !instr_valid |=> !dec_valid ##1 1'b1)
    else $error("decode while idle or disabled");
  a_apb_one_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");

  c_loop_imm: cover property (dec_kind == lid_pkg::KIND_LCNT);
  c_short_move: cover property (dec_mem.valid && $past(instr_short));
  c_bit_op: cover property (dec_bit.valid && dec_bit.op == 3'h4);
  c_long_forced: cover property (dec_mem.long_word_access);
  c_apb_err: cover property (pready && pslverr);
endmodule
`default_nettype wire

// ---- lid_fetch_model.sv ----
// fetch stage model that feeds queued words to the decoder
`default_nettype none
module lid_fetch_model (
  // clock
  input  wire logic        pclk,
  // instruction to decoder
  output logic             instr_valid,
  output logic             instr_short,
  output logic [47:0]      instr_word,
  output logic [23:0]      instr_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [72:0] q [$];

  // queue one word with its short flag and address
  task automatic push(input logic s, input logic [47:0] w,
                      input logic [23:0] a);
    q.push_back({s, w, a});
  endtask

  initial begin
    instr_valid = 1'h0;
    instr_short = 1'h0;
    instr_word  = 48'h0;
    instr_addr  = 24'h0;
  end

  // one word a cycle; idle cycles invert the word so stale data never
  // passes for a fresh instruction
  always @(posedge pclk) begin
    if (q.size() != 0) begin
      {instr_short, instr_word, instr_addr} <= q.pop_front();
      instr_valid <= 1'h1;
    end else begin
      instr_valid <= 1'h0;
      instr_word  <= ~instr_word;
    end
  end
endmodule
`default_nettype wire

// ---- lid_map.svh ----
// field positions, opcodes, register offsets and reset values
`ifndef LID_MAP_SVH
`define LID_MAP_SVH
// long form fields, 48-bit word
`define LID_TOP3      47:45
`define LID_OP5       44:40
`define LID_OP6       44:42
`define LID_ZBIT      39
`define LID_LCNT      39:24
`define LID_UREG      38:32
`define LID_TERM      37:33
`define LID_REL       23:0
`define LID_IMM32     31:0
`define LID_G14       41
`define LID_D14       40
`define LID_L14       39
`define LID_G15       44
`define LID_I15       43:41
`define LID_D15       40
`define LID_L15       39
`define LID_B16       44
`define LID_I16       43:41
`define LID_M16       40:38
`define LID_G16       37
`define LID_BIT_OP    39:37
`define LID_SYS_REG   36:32
// short form fields, taken from word bits 47:16
`define LID_SPFX      31:28
`define LID_SI        27:25
`define LID_SD        24
`define LID_SL        23
`define LID_SG15      22
`define LID_SM        24:22
`define LID_SG16      21
`define LID_SSUB      18:16
`define LID_SUREG15   13:7
`define LID_SMOD      6:0
`define LID_SDAT16    15:0
`define LID_STOP3     31:29
`define LID_SOP5      28:24
`define LID_SBIT      23
`define LID_SUREG17   22:16
// opcode values
`define LID_TOP_000   3'h0
`define LID_TOP_100   3'h4
`define LID_TOP_101   3'h5
`define LID_OP_LCNT   5'h0C
`define LID_OP_LUREG  5'h0D
`define LID_OP_LTERM  5'h0E
`define LID_OP_UIMM   5'h0F
`define LID_OP_BIT    5'h14
`define LID_OP6_ABS   3'h4
`define LID_SPFX_VAL  4'h9
`define LID_SSUB_IDX  3'h2
`define LID_SSUB_IM   3'h1
`define LID_BIT_OP_LAST 3'h4
// register offsets and reset values
`define LID_OFF_CTRL  5'h00
`define LID_OFF_NWLO  5'h04
`define LID_OFF_NWHI  5'h08
`define LID_OFF_STAT  5'h0C
`define LID_OFF_LAST  5'h10
`define LID_CTRL_RST  1'h1
`define LID_NWLO_RST  32'h00000000
`define LID_NWHI_RST  32'hFFFFFFFF
`endif

// ---- lid_pkg.sv ----
// types shared by the loop and immediate move decoder
`default_nettype none
package lid_pkg;
  typedef enum logic [3:0] {
    KIND_NONE  = 4'h0,
    KIND_LCNT  = 4'h1,
    KIND_LTERM = 4'h2,
    KIND_MABS  = 4'h3,
    KIND_MIDX  = 4'h4,
    KIND_IMLD  = 4'h5,
    KIND_ULD   = 4'h6,
    KIND_BIT   = 4'h7
  } lid_kind_type;
  typedef struct packed {
    logic        start;
    logic        count_from_ureg;
    logic        until_term;
    logic [15:0] count;
    logic [6:0]  count_ureg;
    logic [4:0]  term;
    logic [23:0] end_addr;
  } lid_loop_type;
  typedef struct packed {
    logic        valid;
    logic        indexed;
    logic        write_mem;
    logic        long_word_req;
    logic        long_word_access;
    logic        gen_sel;
    logic [2:0]  idx;
    logic [6:0]  ureg;
    logic [31:0] addr_or_mod;
  } lid_mem_type;
  typedef struct packed {
    logic        idx_load;
    logic        mod_load;
    logic        ureg_load;
    logic        gen_sel;
    logic [2:0]  reg_sel;
    logic [6:0]  ureg;
    logic [31:0] data;
  } lid_imm_type;
  typedef struct packed {
    logic        valid;
    logic [2:0]  op;
    logic [4:0]  sys_reg_sel;
    logic [31:0] data;
  } lid_bit_type;
endpackage
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the loop and immediate move decoder
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  pclk, presetn, psel, penable, pwrite;
  logic                  pready, pslverr, er, en, vq, go;
  logic                  instr_valid, instr_short, dec_valid;
  logic [4:0]            paddr;
  logic [31:0]           pwdata, prdata, rd, seed, lo, hi;
  logic [31:0]           corner [4];
  logic [47:0]           instr_word;
  logic [23:0]           instr_addr;
  lid_pkg::lid_kind_type dec_kind, ek;
  lid_pkg::lid_loop_type dec_loop, el;
  lid_pkg::lid_mem_type  dec_mem, em;
  lid_pkg::lid_imm_type  dec_imm, ei;
  lid_pkg::lid_bit_type  dec_bit, eb;
  int                    error_cnt, n_tests, i, nd, nb;

  lid_decoder lid_decoder_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_short(instr_short), .instr_word(instr_word),
    .instr_addr(instr_addr), .dec_valid(dec_valid),
    .dec_kind(dec_kind), .dec_loop(dec_loop), .dec_mem(dec_mem),
    .dec_imm(dec_imm), .dec_bit(dec_bit));
  lid_fetch_model lid_fetch_model_inst (.pclk(pclk),
    .instr_valid(instr_valid), .instr_short(instr_short),
    .instr_word(instr_word), .instr_addr(instr_addr));

  always #2.5 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("Error %0t: %s", $time, m);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("Error %0t: apb answer timed out", $time);
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (w && a == 5'h00 && !er) en = d[0];
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e,
                      input logic x);
    apb(1'h0, a, 32'h0);
    chk(rd === e && er === x, "register read");
  endtask

  // expected decode of one word, worked out from the field layout
  function automatic void expd(input logic sh, input logic [47:0] w,
                               input logic [23:0] a);
    logic [31:0] s;
    s = w[47:16];
    ek = lid_pkg::KIND_NONE;
    el = '0;
    em = '0;
    ei = '0;
    eb = '0;
    if (sh) begin
      if (s[31:28] == 4'h9 && s[18:16] == 3'h2) begin
        ek = lid_pkg::KIND_MIDX;
        em = '{1'h1, 1'h1, s[24], s[23], 1'h0, s[22], s[27:25],
               s[13:7], {{25{s[6]}}, s[6:0]}};
      end else if (s[31:28] == 4'h9 && s[18:16] == 3'h1) begin
        ek = lid_pkg::KIND_IMLD;
        ei = '{1'h1, 1'h1, 1'h0, s[21], s[27:25], {4'h0, s[24:22]},
               {{16{s[15]}}, s[15:0]}};
      end else if (s[31:23] == 9'h01F) begin
        ek = lid_pkg::KIND_ULD;
        ei = '{1'h0, 1'h0, 1'h1, 1'h0, 3'h0, s[22:16],
               {{16{s[15]}}, s[15:0]}};
      end
    end else if (w[47:45] == 3'h5) begin
      ek = lid_pkg::KIND_MIDX;
      em = '{1'h1, 1'h1, w[40], w[39], 1'h0, w[44], w[43:41],
             w[38:32], w[31:0]};
    end else if (w[47:44] == 4'h9) begin
      ek = lid_pkg::KIND_IMLD;
      ei = '{1'h1, 1'h1, 1'h0, w[37], w[43:41], {4'h0, w[40:38]},
             w[31:0]};
    end else if (w[47:42] == 6'h04) begin
      ek = lid_pkg::KIND_MABS;
      em = '{1'h1, 1'h0, w[40], w[39],
             w[39] && w[31:0] >= lo && w[31:0] <= hi, w[41], 3'h0,
             w[38:32], w[31:0]};
    end else if (w[47:45] == 3'h0) begin
      case (w[44:40])
        5'h0C: begin
          ek = lid_pkg::KIND_LCNT;
          el = '{1'h1, 1'h0, 1'h0, w[39:24], 7'h0, 5'h0, a + w[23:0]};
        end
        5'h0D: if (!w[39]) begin
          ek = lid_pkg::KIND_LCNT;
          el = '{1'h1, 1'h1, 1'h0, 16'h0, w[38:32], 5'h0, a + w[23:0]};
        end
        5'h0E: begin
          ek = lid_pkg::KIND_LTERM;
          el = '{1'h1, 1'h0, 1'h1, 16'h0, 7'h0, w[37:33], a + w[23:0]};
        end
        5'h0F: if (!w[39]) begin
          ek = lid_pkg::KIND_ULD;
          ei = '{1'h0, 1'h0, 1'h1, 1'h0, 3'h0, w[38:32], w[31:0]};
        end
        5'h14: if (w[39:37] <= 3'h4) begin
          ek = lid_pkg::KIND_BIT;
          eb = '{1'h1, w[39:37], w[36:32], w[31:0]};
        end
        default: ;
      endcase
    end
  endfunction

  // build one word of the chosen form and hand it to the fetch model
  task automatic gen(input int f);
    logic [47:0] w;
    logic [31:0] t;
    logic        s;
    w[47:16] = rnd();
    t = rnd();
    w[15:0] = t[15:0];
    t = rnd();
    s = 1'h0;
    case (f)
      0: w[47:40] = 8'h0C;
      1: w[47:40] = 8'h0D;
      2: w[47:40] = 8'h0E;
      3: begin
        w[47:42] = 6'h04;
        if (t[16]) w[31:0] = corner[t[18:17]];
      end
      4: w[47:45] = 3'h5;
      5: w[47:44] = 4'h9;
      6: w[47:40] = 8'h0F;
      7: w[47:40] = 8'h14;
      8: {s, w[47:44], w[34:32]} = {1'h1, 4'h9, 3'h2};
      9: {s, w[47:44], w[34:32]} = {1'h1, 4'h9, 3'h1};
      10: {s, w[47:39]} = {1'h1, 9'h01F};
      default: s = t[20];
    endcase
    lid_fetch_model_inst.push(s, w, t[23:0]);
    @(posedge pclk);
  endtask

  // take the expectation for the word the decoder samples at this edge
  always @(posedge pclk) begin
    vq <= instr_valid === 1'h1 && en === 1'h1 && presetn === 1'h1;
    if (instr_valid === 1'h1) expd(instr_short, instr_word, instr_addr);
    // mirror the status counters: only enabled words count
    if (instr_valid === 1'h1 && en === 1'h1 && presetn === 1'h1) begin
      if (ek != lid_pkg::KIND_NONE) nd++;
      else nb++;
    end
  end

  // outputs are settled by the falling edge
  always @(negedge pclk) if (go) begin
    chk(dec_valid === (vq && ek != lid_pkg::KIND_NONE), "valid");
    chk(dec_kind === (vq ? ek : lid_pkg::KIND_NONE), "kind");
    chk({dec_loop, dec_mem, dec_imm, dec_bit} ===
        (vq ? {el, em, ei, eb} : '0), "all fields");
    if (vq) case (ek)
      lid_pkg::KIND_LCNT, lid_pkg::KIND_LTERM: begin
        chk(dec_loop.end_addr === el.end_addr, "loop end");
        chk(dec_loop.until_term === el.until_term &&
            dec_loop.count_from_ureg === el.count_from_ureg, "loop kind");
        chk(el.count_from_ureg ? dec_loop.count_ureg === el.count_ureg
          : el.until_term ? dec_loop.term === el.term
          : dec_loop.count === el.count, "loop field");
      end
      lid_pkg::KIND_MABS, lid_pkg::KIND_MIDX:
        chk(dec_mem === em, "memory move");
      lid_pkg::KIND_IMLD, lid_pkg::KIND_ULD:
        chk(dec_imm === ei, "immediate load");
      lid_pkg::KIND_BIT: chk(dec_bit === eb, "bit op");
      default: ;
    endcase
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, go} = '0;
    paddr = 5'h00;
    pwdata = 32'h0;
    seed = 32'h00009B0C;
    nd = 0;
    nb = 0;
    en = 1'h1;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    go = 1'h1;
    rchk(5'h00, 32'h00000001, 1'h0);
    rchk(5'h04, 32'h00000000, 1'h0);
    rchk(5'h08, 32'hFFFFFFFF, 1'h0);
    rchk(5'h14, 32'h00000000, 1'h1);
    lo = 32'h00001000;
    hi = 32'h0000FFFF;
    corner = '{lo - 32'h1, lo, hi, hi + 32'h1};
    apb(1'h1, 5'h04, lo);
    apb(1'h1, 5'h08, hi);
    rchk(5'h08, hi, 1'h0);
    $display("test registers done");
    for (i = 0; i < 1200; i++) gen(i % 12);
    repeat (3) @(posedge pclk);
    $display("test random decode done");
    apb(1'h1, 5'h00, 32'h0);
    for (i = 0; i < 24; i++) gen(i % 12);
    repeat (3) @(posedge pclk);
    apb(1'h1, 5'h00, 32'h1);
    for (i = 0; i < 12; i++) gen(i);
    repeat (3) @(posedge pclk);
    rchk(5'h0C, {nb[15:0], nd[15:0]}, 1'h0);
    $display("test disable done");
    conclude();
  end
endmodule
`default_nettype wire
